// ---- pkg/ana_pkg.sv ----
// Package for the auto-negotiation ability register bank
package ana_pkg;

  // ==========================================================================
  // Register map (word offsets on the management port)
  localparam logic [4:0]  ANA_ADV_OFFSET     = 5'h04;
  localparam logic [4:0]  ANA_LPA_OFFSET     = 5'h05;

  // ==========================================================================
  // Advertisement field positions
  localparam int          ANA_ADV_TOP_HI     = 15;
  localparam int          ANA_ADV_TOP_LO     = 14;
  localparam int          ANA_ADV_RFAULT     = 13;
  localparam int          ANA_ADV_SPARE12    = 12;
  localparam int          ANA_ADV_PAUSE_HI   = 11;
  localparam int          ANA_ADV_PAUSE_LO   = 10;
  localparam int          ANA_ADV_SPARE9     = 9;
  localparam int          ANA_ADV_CAP_HI     = 8;
  localparam int          ANA_ADV_CAP_LO     = 5;

  // ==========================================================================
  // Reset values
  localparam logic [1:0]  ANA_ADV_TOP_RST    = 2'h2;
  localparam logic [1:0]  ANA_PAUSE_RST      = 2'h0;
  localparam logic [4:0]  ANA_ADV_SEL_VAL    = 5'h01;
  localparam logic [4:0]  ANA_LPA_SEL_RST    = 5'h00;
  localparam logic [3:0]  ANA_CAP_MULTI      = 4'hf;
  localparam logic [3:0]  ANA_CAP_SINGLE     = 4'h0;
  localparam logic [15:0] ANA_LPA_RST        = 16'h0000;

  // ==========================================================================
  // Pause encodings
  localparam logic [1:0]  ANA_PAUSE_NONE     = 2'h0;
  localparam logic [1:0]  ANA_PAUSE_SYM      = 2'h1;
  localparam logic [1:0]  ANA_PAUSE_ASYM     = 2'h2;
  localparam logic [1:0]  ANA_PAUSE_BOTH     = 2'h3;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic       top_hi;
    logic       top_lo;
    logic       rfault;
    logic       spare12;
    logic [1:0] pause;
    logic       spare9;
    logic [3:0] cap;
    logic [4:0] selector;
  } ana_adv_type;

  typedef struct packed {
    logic       next_page;
    logic       ack;
    logic       rfault;
    logic       spare12;
    logic [1:0] pause;
    logic [4:0] spare9_5;
    logic [4:0] selector;
  } ana_lpa_type;

  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ana_req_type;

endpackage : ana_pkg

// ---- design/ana_page_capture.sv ----
// Captures the partner base page into the partner ability register
`timescale 1ns/1ps
module ana_page_capture
  import ana_pkg::*;
(
  // Clock and resets
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        sw_reset,
  // Received page
  input  wire logic        page_valid,
  input  wire logic [15:0] page_word,
  // Register contents
  output ana_lpa_type      lpa_reg
);

  // ==========================================================================
  // Whole word loads at once so software never sees a mixed page
  always_ff @(posedge clk) begin
    if (rst || sw_reset) begin
      lpa_reg <= ANA_LPA_RST;
    end else if (page_valid) begin
      lpa_reg           <= page_word;
      lpa_reg.spare12   <= 1'b0;
      lpa_reg.spare9_5  <= 5'h00;
    end
  end

  // ==========================================================================
  // Checks
  a_lpa_clear: assert property (@(posedge clk) (rst || sw_reset) |=> lpa_reg == ANA_LPA_RST)
    else $error("partner register not cleared by reset");
  a_lpa_load: assert property (@(posedge clk) disable iff (rst)
      (page_valid && !sw_reset) |=> lpa_reg.pause == $past(page_word[11:10]))
    else $error("partner page not loaded");
  a_lpa_unused: assert property (@(posedge clk) disable iff (rst)
      (page_valid && !sw_reset) |=> lpa_reg.spare12 == 1'b0 && lpa_reg.spare9_5 == 5'h00)
    else $error("unused partner bit set");

endmodule : ana_page_capture

// ---- design/ana_regs.sv ----
// Auto-negotiation advertisement and partner ability register bank
`timescale 1ns/1ps
// Operation
// - remote fault bit RW, effective on restart
// - pause field encoded, retained on soft reset
// - four speed/duplex bits, variant reset value
// - capability bits retained, applied on restart
// - advertisement selector reads 00001, read-only
// - partner next page bit, cleared on reset
// - partner acknowledge bit, cleared on reset
// - partner remote fault bit, cleared on reset
// - partner pause field, reset to 00
// - partner selector 00000, unused bits zero
module ana_regs
  import ana_pkg::*;
#(
  parameter bit MULTI_SPEED = 1'b1
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Management register port
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Control from the control register
  input  wire logic        sw_reset,
  input  wire logic        an_restart,
  input  wire logic        link_down,
  // Received partner base page
  input  wire logic        page_valid,
  input  wire logic [15:0] page_word,
  // Advertisement in force on the line
  output ana_adv_type      adv_active
);

  // ==========================================================================
  // State
  // Each field keeps its own register so that every flop has exactly one
  // writing process; the struct below is only a combinational view of them.
  ana_adv_type adv_reg;
  ana_lpa_type lpa_reg;
  logic [1:0]  top_reg;
  logic        rfault_reg;
  logic        spare12_reg;
  logic [1:0]  pause_reg;
  logic        spare9_reg;
  logic [3:0]  cap_reg;
  logic [3:0]  cap_rst;
  logic        restart;
  logic        adv_write;

  assign cap_rst = MULTI_SPEED ? ANA_CAP_MULTI : ANA_CAP_SINGLE;
  assign restart = an_restart || link_down;

  // Address decode shared by read and write paths
  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    hit = (a == off);
  endfunction : hit

  // Write strobe aimed at the advertisement word
  assign adv_write = reg_wr && hit(reg_addr, ANA_ADV_OFFSET);

  // ==========================================================================
  // Advertisement: top bits reset to 10 on both resets, software must keep them.
  // A write that changes them is stored as given, so a careless driver shows on the line.
  always_ff @(posedge clk) begin
    if (rst) begin
      top_reg <= ANA_ADV_TOP_RST;
    end else if (sw_reset) begin
      top_reg <= ANA_ADV_TOP_RST;
    end else if (adv_write) begin
      top_reg <= reg_wdata[ANA_ADV_TOP_HI:ANA_ADV_TOP_LO];
    end
  end

  // Remote fault: cleared by hard reset, kept by soft reset
  always_ff @(posedge clk) begin
    if (rst) begin
      rfault_reg <= 1'b0;
    end else if (adv_write && !sw_reset) begin
      rfault_reg <= reg_wdata[ANA_ADV_RFAULT];
    end
  end

  // Spare bit 12: same reset behaviour as the fault bit
  always_ff @(posedge clk) begin
    if (rst) begin
      spare12_reg <= 1'b0;
    end else if (adv_write && !sw_reset) begin
      spare12_reg <= reg_wdata[ANA_ADV_SPARE12];
    end
  end

  // Pause field: a write that meets a soft reset is dropped, not half taken
  always_ff @(posedge clk) begin
    if (rst) begin
      pause_reg <= ANA_PAUSE_RST;
    end else if (adv_write && !sw_reset) begin
      pause_reg <= reg_wdata[ANA_ADV_PAUSE_HI:ANA_ADV_PAUSE_LO];
    end
  end

  // Spare bit 9 clears on both resets
  always_ff @(posedge clk) begin
    if (rst || sw_reset) begin
      spare9_reg <= 1'b0;
    end else if (adv_write) begin
      spare9_reg <= reg_wdata[ANA_ADV_SPARE9];
    end
  end

  // Capability bits: variant reset, retained across soft reset
  always_ff @(posedge clk) begin
    if (rst) begin
      cap_reg <= cap_rst;
    end else if (adv_write && !sw_reset) begin
      cap_reg <= reg_wdata[ANA_ADV_CAP_HI:ANA_ADV_CAP_LO];
    end
  end

  // Word view of the advertisement; the selector is a constant, so writes
  // to it have nowhere to land
  always_comb begin
    adv_reg          = '0;
    adv_reg.top_hi   = top_reg[1];
    adv_reg.top_lo   = top_reg[0];
    adv_reg.rfault   = rfault_reg;
    adv_reg.spare12  = spare12_reg;
    adv_reg.pause    = pause_reg;
    adv_reg.spare9   = spare9_reg;
    adv_reg.cap      = cap_reg;
    adv_reg.selector = ANA_ADV_SEL_VAL;
  end

  // ==========================================================================
  // Advertisement in force: stored values reach the line only on restart.
  // Capability bits follow the restart bit only; fault and pause also follow
  // a link drop.
  always_ff @(posedge clk) begin
    if (rst) begin
      adv_active          <= '0;
      adv_active.top_hi   <= ANA_ADV_TOP_RST[1];
      adv_active.cap      <= cap_rst;
      adv_active.selector <= ANA_ADV_SEL_VAL;
    end else begin
      if (restart) begin
        adv_active.top_hi  <= adv_reg.top_hi;
        adv_active.top_lo  <= adv_reg.top_lo;
        adv_active.rfault  <= adv_reg.rfault;
        adv_active.spare12 <= adv_reg.spare12;
        adv_active.pause   <= adv_reg.pause;
        adv_active.spare9  <= adv_reg.spare9;
      end
      if (an_restart) begin
        adv_active.cap <= adv_reg.cap;
      end
    end
  end

  // ==========================================================================
  // Partner ability register
  ana_page_capture u_capture (
    .clk        (clk),
    .rst        (rst),
    .sw_reset   (sw_reset),
    .page_valid (page_valid),
    .page_word  (page_word),
    .lpa_reg    (lpa_reg)
  );

  // ==========================================================================
  // Read data, valid only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (hit(reg_addr, ANA_ADV_OFFSET)) begin
        reg_rdata <= adv_reg;
      end else if (hit(reg_addr, ANA_LPA_OFFSET)) begin
        reg_rdata <= lpa_reg;
      end else begin
        reg_rdata <= 16'h0000; // Unmapped reads as zero
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ==========================================================================
  // Checks
  a_adv_top_reset: assert property (@(posedge clk) (rst || sw_reset) |=>
      {adv_reg.top_hi, adv_reg.top_lo} == ANA_ADV_TOP_RST)
    else $error("top bits not at reset pattern");
  a_rfault_retain: assert property (@(posedge clk) disable iff (rst)
      sw_reset |=> adv_reg.rfault == $past(adv_reg.rfault))
    else $error("remote fault lost on soft reset");
  a_pause_hold: assert property (@(posedge clk) disable iff (rst)
      (!restart ##1 1'b1) |-> adv_active.pause == $past(adv_active.pause))
    else $error("pause applied without restart");
  a_cap_reset: assert property (@(posedge clk) rst |=> adv_reg.cap == cap_rst)
    else $error("capability reset value wrong");
  a_cap_apply: assert property (@(posedge clk) disable iff (rst)
      an_restart |=> adv_active.cap == $past(adv_reg.cap))
    else $error("capability not applied on restart");
  a_cap_retain: assert property (@(posedge clk) disable iff (rst)
      sw_reset |=> adv_reg.cap == $past(adv_reg.cap))
    else $error("capability lost on soft reset");
  a_sel_read: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == ANA_ADV_OFFSET) |=> reg_rdata[4:0] == ANA_ADV_SEL_VAL)
    else $error("selector misread");
  a_lpa_read: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == ANA_LPA_OFFSET) |=> reg_rdata[9:5] == 5'h00 && reg_rdata[12] == 1'b0)
    else $error("unused partner bits read nonzero");
  a_rd_idle: assert property (@(posedge clk) disable iff (rst) !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");

  // Stored values reach the line only through a restart
  a_rfault_apply: assert property (@(posedge clk) disable iff (rst)
      restart |=> adv_active.rfault == $past(adv_reg.rfault))
    else $error("remote fault not applied on restart");
  a_pause_apply: assert property (@(posedge clk) disable iff (rst)
      restart |=> adv_active.pause == $past(adv_reg.pause))
    else $error("pause not applied on restart");
  a_top_apply: assert property (@(posedge clk) disable iff (rst)
      restart |=> {adv_active.top_hi, adv_active.top_lo} == $past(top_reg))
    else $error("top bits not applied on restart");
  a_cap_drop_hold: assert property (@(posedge clk) disable iff (rst)
      (link_down && !an_restart) |=> adv_active.cap == $past(adv_active.cap))
    else $error("capability applied on link drop");

  // Reset and write behaviour of the stored word, and reset of the active word
  a_rfault_reset: assert property (@(posedge clk) rst |=> adv_reg.rfault == 1'b0)
    else $error("remote fault not cleared by hard reset");
  a_pause_retain: assert property (@(posedge clk) disable iff (rst)
      sw_reset |=> adv_reg.pause == $past(adv_reg.pause))
    else $error("pause lost on soft reset");
  a_cap_write: assert property (@(posedge clk) disable iff (rst)
      (adv_write && !sw_reset) |=> adv_reg.cap == $past(reg_wdata[ANA_ADV_CAP_HI:ANA_ADV_CAP_LO]))
    else $error("capability write not stored");
  a_spare9_clear: assert property (@(posedge clk) (rst || sw_reset) |=> adv_reg.spare9 == 1'b0)
    else $error("spare bit 9 not cleared by reset");
  a_active_reset: assert property (@(posedge clk) rst |=>
      adv_active.selector == ANA_ADV_SEL_VAL && adv_active.cap == cap_rst)
    else $error("active advertisement reset wrong");

  // Read path, and partner register hold without a page
  a_rd_adv_data: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == ANA_ADV_OFFSET) |=> reg_rdata == $past(adv_reg))
    else $error("advertisement read data wrong");
  a_rd_lpa_data: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == ANA_LPA_OFFSET) |=> reg_rdata == $past(lpa_reg))
    else $error("partner read data wrong");
  a_rd_unmapped: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr != ANA_ADV_OFFSET && reg_addr != ANA_LPA_OFFSET) |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_lpa_hold: assert property (@(posedge clk) disable iff (rst)
      (!page_valid && !sw_reset) |=> lpa_reg == $past(lpa_reg))
    else $error("partner register changed without a page");

  c_restart: cover property (@(posedge clk) disable iff (rst) reg_wr ##[1:4] an_restart);
  c_page:    cover property (@(posedge clk) disable iff (rst) page_valid ##1 reg_rd);
  c_soft:    cover property (@(posedge clk) disable iff (rst) reg_wr ##1 sw_reset);
  c_drop:    cover property (@(posedge clk) disable iff (rst) link_down ##[1:4] reg_rd);
  c_hard:    cover property (@(posedge clk) rst ##1 !rst ##[1:4] reg_rd);

endmodule : ana_regs

// ---- sim/ana_partner.sv ----
// Behavioural link partner that hands received base pages to the register bank
`timescale 1ns/1ps
module ana_partner
  import ana_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Bench request
  input  wire logic        send,
  input  wire logic [15:0] word,
  // Received page
  output logic             page_valid,
  output logic      [15:0] page_word
);
  // ==========================================================================
  // Page delivery
  // Word is inverted once the strobe drops so a stale page never looks valid
  always_ff @(posedge clk) begin
    if (rst) begin
      page_valid <= 1'b0;
      page_word  <= 16'h0000;
    end else begin
      page_valid <= send;
      if (send) begin
        page_word <= word;
      end else if (page_valid) begin
        page_word <= ~page_word;
      end
    end
  end
endmodule : ana_partner

// ---- sim/testbench.sv ----
// Self-checking bench for the ability register bank
`timescale 1ns/1ps
module testbench;
  import ana_pkg::*;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, send = 1'b0;
  logic sw_reset = 1'b0, an_restart = 1'b0, link_down = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, word = 16'h0000, reg_rdata, page_word, w, prev;
  logic page_valid;
  ana_adv_type adv_active;
  int num_errors = 0, cmp_count = 0;

  // ==========================================================================
  // Clock, design and partner
  initial forever #2.5 clk = ~clk;
  ana_regs #(.MULTI_SPEED(1'b1)) i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sw_reset(sw_reset), .an_restart(an_restart),
    .link_down(link_down), .page_valid(page_valid), .page_word(page_word), .adv_active(adv_active));
  ana_partner i_partner (.clk(clk), .rst(rst), .send(send), .word(word), .page_valid(page_valid),
    .page_word(page_word));

  // ==========================================================================
  // Access tasks
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      num_errors++;
    end
  endtask : check

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
    @(posedge clk) reg_wr <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe, so sample right there
  task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string name);
    @(posedge clk) begin reg_rd <= 1'b1; reg_addr <= a; end
    @(posedge clk) reg_rd <= 1'b0;
    #1 check(name, reg_rdata, exp);
  endtask : rd

  // One-cycle pulse on {sw_reset, an_restart, link_down}
  task automatic ctl(input logic [2:0] m);
    @(posedge clk) {sw_reset, an_restart, link_down} <= m;
    @(posedge clk) {sw_reset, an_restart, link_down} <= 3'b000;
    #1;
  endtask : ctl

  task automatic page(input logic [15:0] d);
    @(posedge clk) begin send <= 1'b1; word <= d; end
    @(posedge clk) send <= 1'b0;
    @(posedge clk);
  endtask : page

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // ==========================================================================
  // Watchdog, far beyond the less than a hundred cycles the tests need
  initial begin
    #20us;
    num_errors++;
    final_report();
  end

  // ==========================================================================
  // Tests
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(5'h04, 16'h81e1, "adv reset");
    rd(5'h05, ANA_LPA_RST, "lpa reset");
    rd(5'h00, 16'h0000, "unmapped read");
    check("active reset", adv_active, 16'h81e1);
    $display("test reset values done");
    // Every pause code, with writes held back until restart
    prev = 16'h81e1;
    for (int p = 0; p < 4; p++) begin
      w = {2'b10, p[0], 1'b0, p[1:0], 1'b0, p[1:0], p[1:0], 5'h1f};
      wr(5'h04, w);
      rd(5'h04, {w[15:5], ANA_ADV_SEL_VAL}, "adv write");
      check("active held", adv_active, prev);
      ctl(3'b010);
      prev = {w[15:5], ANA_ADV_SEL_VAL};
      check("active restart", adv_active, prev);
    end
    $display("test pause codes done");
    wr(5'h04, 16'h8400);
    ctl(3'b001);
    check("rf link drop", 16'(adv_active.rfault), 16'h0000);
    check("pause link drop", 16'(adv_active.pause), 16'(ANA_PAUSE_SYM));
    check("cap link drop", 16'(adv_active.cap), 16'h000f);
    $display("test link drop done");
    wr(5'h04, 16'hb601);
    page(16'hffff);
    rd(5'h05, 16'hec1f, "lpa all ones");
    wr(5'h05, 16'h0000);
    rd(5'h05, 16'hec1f, "lpa read only");
    ctl(3'b100);
    rd(5'h04, 16'hb401, "adv soft reset");
    rd(5'h05, 16'h0000, "lpa soft reset");
    page(16'h6801);
    rd(5'h05, 16'h6801, "lpa fields");
    $display("test soft reset done");
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    rd(5'h04, 16'h81e1, "adv hard reset");
    rd(5'h05, 16'h0000, "lpa hard reset");
    check("active hard reset", adv_active, 16'h81e1);
    $display("test hard reset done");
    final_report();
  end
endmodule : testbench
